/* core/tcoc_cfg.svh */
// Register map and field positions for the compare output control block
`ifndef TCOC_CFG_SVH
`define TCOC_CFG_SVH
`define TCOC_OUT_CTRL_ADDR 4'h0
`define TCOC_EDGE_SEL_ADDR 4'h4
`define TCOC_PIN_STAT_ADDR 4'h8
`define TCOC_OUT_CTRL_RST 8'h00
`define TCOC_EDGE_SEL_RST 4'h0
`define TCOC_FIXED_B_POS 6
`define TCOC_FIXED_A_POS 4
`define TCOC_GENERAL_B_POS 2
`define TCOC_GENERAL_A_POS 0
`define TCOC_EDGE_B_POS 2
`define TCOC_EDGE_A_POS 0
`define TCOC_RESP_OKAY 2'h0
`define TCOC_RESP_SLVERR 2'h2
`endif

/* core/tcoc_pkg.sv */
// Types for the compare output control block
package tcoc_pkg;
   typedef enum logic [1:0] {
      TCOC_ACT_OFF = 2'h0,
      TCOC_ACT_LOW = 2'h1,
      TCOC_ACT_HIGH = 2'h2,
      TCOC_ACT_TOGGLE = 2'h3
   } tcoc_act_type;

   typedef struct packed {
      logic fixed_compare_b;
      logic fixed_compare_a;
      logic general_compare_b;
      logic general_compare_a;
   } tcoc_match_type;

   typedef struct packed {
      logic [7:0] out_ctrl;
      logic [3:0] edge_sel;
      logic [3:0] pin;
      logic [3:0] pin_oe;
      logic awvalid_seen;
      logic [3:0] awaddr;
      logic wvalid_seen;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } tcoc_state_type;
endpackage

/* core/tcoc_top.sv */
// Compare-match output control for one timer channel, AXI4-Lite slave
// Functional notes
// - Bits 7:6 pick off, low, high or toggle for fixed compare b.
// - Bits 5:4 pick the same actions for fixed compare a.
// - Bits 3:2 pick the same actions for general compare b.
// - Bits 1:0 pick the same actions for general compare a.
// - Channels 2 and 3 have no toggle; code 11 drives high.
// - General b output is off while its edge select is nonzero.
// - General a output is off while its edge select is nonzero.
// - Control register is eight bits, read-write, resets to zero.
// - General registers compare after reset; nonzero edge select means capture.
`timescale 1ns/10ps
`include "tcoc_cfg.svh"
module tcoc_top
   import tcoc_pkg::*;
#(
   parameter int CHANNEL = 4
) (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire tcoc_match_type match,
   input wire logic [3:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [3:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [3:0] cmp_pin,
   output logic [3:0] cmp_pin_oe
);
   // Only channels 2 to 5 carry this register
   if (CHANNEL < 2 || CHANNEL > 5) begin : gen_bad_channel
      $error("tcoc_top: CHANNEL must be 2 to 5");
   end

   localparam int SRC_COUNT = 4;
   localparam int DATA_W = 32;
   localparam int CTRL_W = 8;
   localparam int EDGE_W = 4;
   localparam logic NO_TOGGLE = (CHANNEL == 2) || (CHANNEL == 3);

   tcoc_state_type state_reg;
   tcoc_state_type state_next;

   function automatic logic apply_act(input logic [1:0] act, input logic cur);
      logic res;
      res = cur;
      unique case (tcoc_act_type'(act))
         TCOC_ACT_OFF: res = cur;
         TCOC_ACT_LOW: res = 1'b0;
         TCOC_ACT_HIGH: res = 1'b1;
         TCOC_ACT_TOGGLE: res = NO_TOGGLE ? 1'b1 : ~cur;
      endcase
      return res;
   endfunction

   logic [3:0] hit;
   logic [1:0] act [SRC_COUNT];
   logic [3:0] enab;
   logic [DATA_W-1:0] rd_word;
   logic [CTRL_W-1:0] wr_ctrl;
   logic [1:0] edge_b;
   logic [1:0] edge_a;
   logic capture_b;
   logic capture_a;
   logic aw_take;
   logic w_take;
   logic wr_commit;
   logic b_take;
   logic ar_take;
   logic r_take;
   logic aw_mapped;
   logic ar_mapped;

   always_comb begin
      act[3] = state_reg.out_ctrl[`TCOC_FIXED_B_POS +: 2];
      act[2] = state_reg.out_ctrl[`TCOC_FIXED_A_POS +: 2];
      act[1] = state_reg.out_ctrl[`TCOC_GENERAL_B_POS +: 2];
      act[0] = state_reg.out_ctrl[`TCOC_GENERAL_A_POS +: 2];
      hit = {match.fixed_compare_b, match.fixed_compare_a,
             match.general_compare_b, match.general_compare_a};
      enab[3] = act[3] != 2'h0;
      enab[2] = act[2] != 2'h0;
      // Edge select fields of the general registers
      edge_b = state_reg.edge_sel[`TCOC_EDGE_B_POS +: 2];
      edge_a = state_reg.edge_sel[`TCOC_EDGE_A_POS +: 2];
      capture_b = edge_b != 2'h0;
      capture_a = edge_a != 2'h0;
      enab[1] = (act[1] != TCOC_ACT_OFF) && !capture_b;
      enab[0] = (act[0] != TCOC_ACT_OFF) && !capture_a;
   end

   // Handshake strobes of the register bus
   always_comb begin
      aw_take = s_axi_awvalid && state_reg.awready;
      w_take = s_axi_wvalid && state_reg.wready;
      wr_commit = state_reg.awvalid_seen && state_reg.wvalid_seen && !state_reg.bvalid;
      b_take = state_reg.bvalid && s_axi_bready;
      ar_take = s_axi_arvalid && state_reg.arready;
      r_take = state_reg.rvalid && s_axi_rready;
      aw_mapped = (state_reg.awaddr == `TCOC_OUT_CTRL_ADDR) ||
                  (state_reg.awaddr == `TCOC_EDGE_SEL_ADDR) ||
                  (state_reg.awaddr == `TCOC_PIN_STAT_ADDR);
      ar_mapped = (s_axi_araddr == `TCOC_OUT_CTRL_ADDR) ||
                  (s_axi_araddr == `TCOC_EDGE_SEL_ADDR) ||
                  (s_axi_araddr == `TCOC_PIN_STAT_ADDR);
   end

   always_comb begin
      state_next = state_reg;
      wr_ctrl = state_reg.out_ctrl;
      rd_word = 32'h0000_0000;
      for (int i = 0; i < SRC_COUNT; i++) begin
         state_next.pin_oe[i] = enab[i];
         if (enab[i] && hit[i]) begin
            state_next.pin[i] = apply_act(act[i], state_reg.pin[i]);
         end
      end
      // Write channels, taken in either order
      if (aw_take) begin
         state_next.awvalid_seen = 1'b1;
         state_next.awaddr = s_axi_awaddr;
         state_next.awready = 1'b0;
      end
      if (w_take) begin
         state_next.wvalid_seen = 1'b1;
         state_next.wdata = s_axi_wdata;
         state_next.wstrb = s_axi_wstrb;
         state_next.wready = 1'b0;
      end
      // Write lands one cycle after both channels are taken
      if (wr_commit) begin
         state_next.bvalid = 1'b1;
         state_next.bresp = aw_mapped ? `TCOC_RESP_OKAY : `TCOC_RESP_SLVERR;
         state_next.awvalid_seen = 1'b0;
         state_next.wvalid_seen = 1'b0;
         unique case (state_reg.awaddr)
            `TCOC_OUT_CTRL_ADDR: begin
               if (state_reg.wstrb[0]) begin
                  wr_ctrl = state_reg.wdata[CTRL_W-1:0];
               end
               state_next.out_ctrl = wr_ctrl;
            end
            `TCOC_EDGE_SEL_ADDR: begin
               if (state_reg.wstrb[0]) begin
                  state_next.edge_sel = state_reg.wdata[EDGE_W-1:0];
               end
            end
            // Pin status is read only; other offsets hold nothing
            default: wr_ctrl = state_reg.out_ctrl;
         endcase
      end
      if (b_take) begin
         state_next.bvalid = 1'b0;
         state_next.awready = 1'b1;
         state_next.wready = 1'b1;
      end
      // Read channel, data chosen from the live read address
      unique case (s_axi_araddr)
         `TCOC_OUT_CTRL_ADDR: rd_word = DATA_W'(state_reg.out_ctrl);
         `TCOC_EDGE_SEL_ADDR: rd_word = DATA_W'(state_reg.edge_sel);
         `TCOC_PIN_STAT_ADDR: rd_word = DATA_W'({state_reg.pin_oe, state_reg.pin});
         default: rd_word = '0;
      endcase
      if (ar_take) begin
         state_next.arready = 1'b0;
         state_next.rvalid = 1'b1;
         state_next.rdata = rd_word;
         state_next.rresp = ar_mapped ? `TCOC_RESP_OKAY : `TCOC_RESP_SLVERR;
      end
      if (r_take) begin
         state_next.rvalid = 1'b0;
         state_next.arready = 1'b1;
      end
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         state_reg <= '0;
         state_reg.out_ctrl <= `TCOC_OUT_CTRL_RST;
         state_reg.edge_sel <= `TCOC_EDGE_SEL_RST;
         state_reg.awready <= 1'b1;
         state_reg.wready <= 1'b1;
         state_reg.arready <= 1'b1;
      end else begin
         state_reg <= state_next;
      end
   end

   assign s_axi_awready = state_reg.awready;
   assign s_axi_wready = state_reg.wready;
   assign s_axi_bvalid = state_reg.bvalid;
   assign s_axi_bresp = state_reg.bresp;
   assign s_axi_arready = state_reg.arready;
   assign s_axi_rvalid = state_reg.rvalid;
   assign s_axi_rdata = state_reg.rdata;
   assign s_axi_rresp = state_reg.rresp;
   assign cmp_pin = state_reg.pin;
   assign cmp_pin_oe = state_reg.pin_oe;
endmodule

/* test/tcoc_pin_sink.sv */
// Pin model outside the block
`timescale 1ns/10ps
module tcoc_pin_sink (
   input wire logic [3:0] pin,
   input wire logic [3:0] oe,
   output logic [3:0] seen
);
   assign seen = pin & oe;
endmodule

/* test/tcoc_props.sv */
// Checker of bus handshakes and pin holding
`timescale 1ns/10ps
module tcoc_props
   import tcoc_pkg::*;
(
   input wire logic mclk,
   input wire logic sys_rst,
   input wire tcoc_match_type match,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [3:0] cmp_pin
);
   default clocking dc @(posedge mclk); endclocking
   default disable iff (sys_rst);
   a_pin_hold: assert property (match == 4'h0 |=> $stable(cmp_pin))
      else $error("pin moved");
   a_pin_a_hold: assert property (!match[0] |=> cmp_pin[0] == $past(cmp_pin[0]))
      else $error("pin 0 moved");
   a_b_latency: assert property (s_axi_awvalid && s_axi_awready
      && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("no write answer");
   a_b_done: assert property (s_axi_bvalid && s_axi_bready |=>
      !s_axi_bvalid && s_axi_awready && s_axi_wready) else $error("write not closed");
   a_w_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write ready early");
   a_r_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("no read answer");
   a_r_done: assert property (s_axi_rvalid && s_axi_rready |=>
      !s_axi_rvalid && s_axi_arready) else $error("read not closed");
   a_r_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read ready early");
endmodule
bind tcoc_top tcoc_props props (.*);

/* test/tb_timer_compare_output_control.sv */
// Self-checking bench for the compare output control block
`timescale 1ns/10ps
`include "tcoc_cfg.svh"
module tb_timer_compare_output_control;
   import tcoc_pkg::*;
   logic mclk = 0, sys_rst = 1, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic s_axi_arvalid = 0, s_axi_rready = 0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [3:0] s_axi_awaddr = 0, s_axi_wstrb = 0, s_axi_araddr = 0;
   logic [3:0] cmp_pin, cmp_pin_oe, pin3, seen, edg, p4, p3, en;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata, got_data, w, seed = 57;
   logic [1:0] s_axi_bresp, s_axi_rresp, got_resp;
   logic [7:0] ctrl;
   tcoc_match_type match = '0;
   int fail_count = 0, check_count = 0;
   tcoc_top #(.CHANNEL(4)) dut (.*);
   tcoc_top #(.CHANNEL(3)) dut3 (.*, .s_axi_awready(), .s_axi_wready(), .s_axi_bresp(),
      .s_axi_bvalid(), .s_axi_arready(), .s_axi_rdata(), .s_axi_rresp(), .s_axi_rvalid(),
      .cmp_pin(pin3), .cmp_pin_oe());
   tcoc_pin_sink pins (.pin(cmp_pin), .oe(cmp_pin_oe), .seen(seen));
   always #50 mclk = !mclk;
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task chk(input logic [31:0] g, input logic [31:0] e);
      check_count++;
      if (g !== e) begin
         fail_count++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task give_verdict();
      if (fail_count == 0 && check_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task bus(input logic wr, input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
      logic ta, tw, td;
      @(posedge mclk);
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} <= {a, a, d, s};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {wr, wr, wr};
      {s_axi_arvalid, s_axi_rready} <= {!wr, !wr};
      td = 0;
      while (!td) begin
         @(negedge mclk);
         ta = wr ? s_axi_awready : s_axi_arready;
         tw = s_axi_wready;
         td = wr ? s_axi_bvalid : s_axi_rvalid;
         {got_resp, got_data} = {wr ? s_axi_bresp : s_axi_rresp, s_axi_rdata};
         @(posedge mclk);
         if (ta) {s_axi_awvalid, s_axi_arvalid} <= 2'h0;
         if (tw && wr) s_axi_wvalid <= 1'h0;
         if (td) {s_axi_bready, s_axi_rready} <= 2'h0;
      end
   endtask
   task step(input logic [3:0] nm);
      logic [1:0] f;
      @(posedge mclk);
      for (int i = 0; i < 4; i++) begin
         f = ctrl[2*i+:2];
         if (match[i] && en[i]) begin
            p4[i] = f == 2'h1 ? 1'h0 : f == 2'h2 ? 1'h1 : !p4[i];
            p3[i] = f != 2'h1;
         end
      end
      match <= nm;
      @(negedge mclk);
      chk(cmp_pin, p4);
      chk(pin3, p3);
      chk(cmp_pin_oe, en);
      chk(seen, p4 & en);
   endtask
   initial begin
      {ctrl, edg, p4, p3, en} = '0;
      repeat (10) @(posedge mclk);
      sys_rst <= 1'h0;
      bus(1'h0, `TCOC_OUT_CTRL_ADDR, '0, '0);
      chk(got_data, '0);
      bus(1'h0, `TCOC_EDGE_SEL_ADDR, '0, '0);
      chk(got_data, '0);
      bus(1'h1, 4'hC, '1, 4'hF);
      chk(got_resp, `TCOC_RESP_SLVERR);
      bus(1'h0, 4'hC, '0, '0);
      chk(got_resp, `TCOC_RESP_SLVERR);
      chk(got_data, '0);
      for (int k = 0; k < 40; k++) begin
         w = rnd();
         bus(1'h1, `TCOC_OUT_CTRL_ADDR, w, w[11:8]);
         chk(got_resp, `TCOC_RESP_OKAY);
         if (w[8]) ctrl = w[7:0];
         bus(1'h1, `TCOC_EDGE_SEL_ADDR, w >> 16, 4'hF);
         edg = w[19:16];
         bus(1'h0, `TCOC_EDGE_SEL_ADDR, '0, '0);
         chk(got_data, edg);
         bus(1'h0, `TCOC_OUT_CTRL_ADDR, '0, '0);
         chk(got_data, ctrl);
         chk(got_resp, `TCOC_RESP_OKAY);
         for (int i = 0; i < 4; i++) en[i] = ctrl[2*i+:2] != 0 && (i > 1 || edg[2*i+:2] == 0);
         repeat (8) step(4'(rnd()));
         step(4'h0);
         bus(1'h0, `TCOC_PIN_STAT_ADDR, '0, '0);
         chk(got_data, {en, p4});
      end
      bus(1'h1, `TCOC_PIN_STAT_ADDR, '1, 4'hF);
      chk(got_resp, `TCOC_RESP_OKAY);
      sys_rst <= 1'h1;
      repeat (2) @(posedge mclk);
      sys_rst <= 1'h0;
      {ctrl, edg, p4, p3, en} = '0;
      step(4'h0);
      bus(1'h0, `TCOC_OUT_CTRL_ADDR, '0, '0);
      chk(got_data, '0);
      give_verdict();
   end
   initial begin
      #3000000;
      fail_count++;
      give_verdict();
   end
endmodule
